// ### core/uadp_uart_data.sv
// uart data path: apb registers, tx/rx fifos and serial engines
module uadp_uart_data
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uadp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic rxd,
  output logic txd
);
  // register state
  logic [7:0] lcrh; // line_control_high
  logic [7:0] ctrl; // enable control
  logic [15:0] baud_div; // bit length in pclk cycles
  logic rsr_fe; // rx_status_reg flags
  logic rsr_pe;
  logic rsr_be;
  logic rsr_oe;
  logic ovr_pend; // overrun waiting for next store
  logic [11:0] rd_entry; // entry returned by current read
  logic rd_take; // current read removes an entry
  // bus decode
  logic setup;
  logic acc;
  logic wr_data;
  logic wr_ecr;
  logic [31:0] rd_val;
  logic rd_hit;
  // fifo wiring
  logic tx_pop;
  logic tx_push;
  logic [7:0] tx_head;
  logic tx_empty;
  logic tx_full;
  logic rx_push;
  logic rx_pop;
  logic [11:0] rx_wdata;
  logic [11:0] rx_head;
  logic rx_empty;
  logic rx_full;
  // serial engines
  uadp_pkg::uadp_tx_t tx_state;
  uadp_pkg::uadp_rx_t rx_state;
  logic [15:0] tx_cnt;
  logic [15:0] rx_cnt;
  logic [2:0] tx_idx;
  logic [2:0] rx_idx;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic rx_parbit;
  logic tx_stop2;
  logic rx_line;
  logic rx_done;
  logic ovr_event;
  logic rx_fe;
  logic rx_pe;
  logic rx_be;
  logic [15:0] bit_len;
  logic [15:0] half_len;
  logic fifo_off;
  logic uart_en;

  // parity bit for a byte under the selected mode
  function automatic logic par_of(input logic [7:0] b, input logic [7:0] lc);
    logic p;
    p = lc[uadp_pkg::LCR_EVEN] ? ^b : ~^b;
    if (lc[uadp_pkg::LCR_STICK])
    begin
      p = !lc[uadp_pkg::LCR_EVEN];
    end
    return p;
  endfunction

  // address match against a register offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  assign fifo_off = !lcrh[uadp_pkg::LCR_FIFO_ON]; // R21
  assign uart_en = ctrl[uadp_pkg::CTRL_EN];
  assign bit_len = (baud_div == '0) ? 16'h0001 : baud_div;
  assign half_len = {1'b0, bit_len[15:1]};
  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign wr_data = acc && pwrite && hit(paddr, uadp_pkg::OFF_DATA);
  assign wr_ecr = acc && pwrite && hit(paddr, uadp_pkg::OFF_RSR);
  assign tx_push = wr_data; // R1
  assign rx_pop = acc && !pwrite && rd_take; // R22

  // receive line synchroniser
  uadp_sync u_rx_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .din(rxd),
    .dout(rx_line)
  );

  // transmit fifo or holding slot
  uadp_fifo #(.WIDTH(uadp_pkg::DATA_W)) u_tx_fifo
  (
    .pclk(pclk),
    .presetn(presetn),
    .single_mode(fifo_off),
    .push(tx_push),
    .wdata(pwdata[7:0]),
    .pop(tx_pop),
    .rdata(tx_head),
    .empty(tx_empty),
    .full(tx_full)
  );

  // receive fifo or holding slot, entries with status
  uadp_fifo #(.WIDTH(uadp_pkg::ENTRY_W)) u_rx_fifo
  (
    .pclk(pclk),
    .presetn(presetn),
    .single_mode(fifo_off),
    .push(rx_push),
    .wdata(rx_wdata),
    .pop(rx_pop),
    .rdata(rx_head),
    .empty(rx_empty),
    .full(rx_full)
  );

  // read mux for the setup cycle
  always_comb
  begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (paddr)
      uadp_pkg::OFF_DATA:
      begin
        rd_val[11:0] = rx_head; // R5 R11
        rd_val[uadp_pkg::POS_OE] = rx_head[uadp_pkg::POS_OE] | ovr_pend; // R6
      end
      uadp_pkg::OFF_RSR: rd_val[3:0] = {rsr_oe, rsr_be, rsr_pe, rsr_fe}; // R12
      uadp_pkg::OFF_FLAG: rd_val[7:3] = {tx_empty, rx_full, tx_full, rx_empty,
                                          !tx_empty || (tx_state != uadp_pkg::tx_idle)};
      uadp_pkg::OFF_DIV: rd_val[15:0] = baud_div;
      uadp_pkg::OFF_LCRH: rd_val[7:0] = lcrh;
      uadp_pkg::OFF_CTRL: rd_val[7:0] = ctrl;
      default: rd_hit = 1'b0;
    endcase
  end

  // apb answer: ready one cycle after setup, error on unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      rd_entry <= '0;
      rd_take <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !rd_hit;
      if (setup)
      begin
        prdata <= pwrite ? '0 : rd_val;
        rd_entry <= rd_val[11:0];
        rd_take <= !pwrite && !rx_empty && hit(paddr, uadp_pkg::OFF_DATA);
      end
    end
  end

  // control registers written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lcrh <= uadp_pkg::RST_LCRH;
      ctrl <= uadp_pkg::RST_CTRL;
      baud_div <= uadp_pkg::RST_DIV;
    end
    else if (acc && pwrite)
    begin
      if (hit(paddr, uadp_pkg::OFF_LCRH))
      begin
        lcrh <= pwdata[7:0];
      end
      if (hit(paddr, uadp_pkg::OFF_CTRL))
      begin
        ctrl <= pwdata[7:0];
      end
      if (hit(paddr, uadp_pkg::OFF_DIV))
      begin
        baud_div <= pwdata[15:0];
      end
    end
  end

  // receive status: flags load on data read, overrun at once, cleared by write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {rsr_oe, rsr_be, rsr_pe, rsr_fe} <= uadp_pkg::RST_RSR; // R17
    end
    else
    begin
      if (wr_ecr)
      begin
        {rsr_be, rsr_pe, rsr_fe} <= 3'h0; // R15
      end
      else if (rx_pop)
      begin
        // R13
        rsr_fe <= rd_entry[uadp_pkg::POS_FE];
        rsr_pe <= rd_entry[uadp_pkg::POS_PE];
        rsr_be <= rd_entry[uadp_pkg::POS_BE];
      end
      // set wins over the clear
      if (ovr_event)
      begin
        rsr_oe <= 1'b1; // R14
      end
      else if (wr_ecr)
      begin
        rsr_oe <= 1'b0; // R15
      end
    end
  end

  // overrun pending until a new character is stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovr_pend <= 1'b0;
    end
    else if (ovr_event)
    begin
      ovr_pend <= 1'b1; // R6
    end
    else if (rx_push)
    begin
      ovr_pend <= 1'b0; // R6
    end
  end

  // transmit engine takes a char only while enabled; the frame always ends
  assign tx_pop = (tx_state == uadp_pkg::tx_idle) && uart_en && !tx_empty; // R19

  // transmit frame: start, eight data, optional parity, one or two stops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state <= uadp_pkg::tx_idle;
      txd <= 1'b1;
      tx_cnt <= '0;
      tx_idx <= '0;
      tx_byte <= '0;
      tx_stop2 <= 1'b0;
    end
    else if (tx_state != uadp_pkg::tx_idle && tx_cnt != '0)
    begin
      tx_cnt <= tx_cnt - 16'h0001;
    end
    else
    begin
      tx_cnt <= bit_len - 16'h0001;
      case (tx_state)
        uadp_pkg::tx_idle:
        begin
          if (tx_pop)
          begin
            tx_byte <= tx_head;
            txd <= 1'b0; // R2
            tx_state <= uadp_pkg::tx_start;
          end
        end
        uadp_pkg::tx_start:
        begin
          txd <= tx_byte[0];
          tx_idx <= 3'h0;
          tx_state <= uadp_pkg::tx_data;
        end
        uadp_pkg::tx_data:
        begin
          if (tx_idx == 3'h7)
          begin
            tx_stop2 <= lcrh[uadp_pkg::LCR_TWO_STOP];
            if (lcrh[uadp_pkg::LCR_PEN])
            begin
              txd <= par_of(tx_byte, lcrh); // R2
              tx_state <= uadp_pkg::tx_par;
            end
            else
            begin
              txd <= 1'b1;
              tx_state <= uadp_pkg::tx_stop;
            end
          end
          else
          begin
            txd <= tx_byte[tx_idx + 3'h1];
            tx_idx <= tx_idx + 3'h1;
          end
        end
        uadp_pkg::tx_par:
        begin
          txd <= 1'b1;
          tx_state <= uadp_pkg::tx_stop;
        end
        uadp_pkg::tx_stop:
        begin
          tx_stop2 <= 1'b0;
          if (!tx_stop2)
          begin
            tx_state <= uadp_pkg::tx_idle;
          end
        end
        default:
        begin
          txd <= 1'b1;
          tx_state <= uadp_pkg::tx_idle;
        end
      endcase
    end
  end

  // receive completion and entry build
  assign rx_done = (rx_state == uadp_pkg::rx_stop) && (rx_cnt == '0);
  assign rx_fe = !rx_line; // R10
  assign rx_pe = lcrh[uadp_pkg::LCR_PEN] && (rx_parbit != par_of(rx_byte, lcrh)); // R9
  // whole word low, stop included: line held low up to the stop sample of a word
  assign rx_be = !rx_line && (rx_byte == 8'h00)
                 && (!lcrh[uadp_pkg::LCR_PEN] || !rx_parbit); // R7
  assign ovr_event = rx_done && rx_full; // R6
  assign rx_push = rx_done && !rx_full; // R16
  assign rx_wdata = {ovr_pend, rx_be, rx_pe, rx_fe, rx_byte}; // R3 R4 R8

  // receive frame: mid-bit sampling, break holds until marking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state <= uadp_pkg::rx_idle;
      rx_cnt <= '0;
      rx_idx <= '0;
      rx_byte <= '0;
      rx_parbit <= 1'b0;
    end
    else if (rx_state != uadp_pkg::rx_idle && rx_state != uadp_pkg::rx_brk
             && rx_cnt != '0)
    begin
      rx_cnt <= rx_cnt - 16'h0001;
    end
    else
    begin
      rx_cnt <= bit_len - 16'h0001;
      case (rx_state)
        uadp_pkg::rx_idle:
        begin
          // new characters start only while enabled
          if (uart_en && !rx_line)
          begin
            rx_cnt <= half_len;
            rx_state <= uadp_pkg::rx_start;
          end
        end
        uadp_pkg::rx_start:
        begin
          rx_idx <= 3'h0;
          rx_state <= rx_line ? uadp_pkg::rx_idle : uadp_pkg::rx_data;
        end
        uadp_pkg::rx_data:
        begin
          rx_byte[rx_idx] <= rx_line;
          rx_idx <= rx_idx + 3'h1;
          if (rx_idx == 3'h7)
          begin
            rx_parbit <= 1'b0;
            rx_state <= lcrh[uadp_pkg::LCR_PEN] ? uadp_pkg::rx_par : uadp_pkg::rx_stop;
          end
        end
        uadp_pkg::rx_par:
        begin
          rx_parbit <= rx_line;
          rx_state <= uadp_pkg::rx_stop;
        end
        uadp_pkg::rx_stop:
        begin
          // after a break, nothing more until the line marks
          rx_state <= rx_be ? uadp_pkg::rx_brk : uadp_pkg::rx_idle; // R8
        end
        uadp_pkg::rx_brk:
        begin
          if (rx_line)
          begin
            rx_state <= uadp_pkg::rx_idle; // R8
          end
        end
        default: rx_state <= uadp_pkg::rx_idle;
      endcase
    end
  end

  // checks on the data path
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_ready: assert property (setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  a_tx_push_fifo: assert property (wr_data && !tx_full |=> !tx_empty) // R1
    else $error("data write did not queue a character");
  a_slot_single: assert property (fifo_off && $past(fifo_off) && wr_data && !tx_empty |-> tx_full) // R21
    else $error("holding slot holds more than one char");
  a_tx_start_bit: assert property (tx_state == uadp_pkg::tx_start |-> !txd) // R2
    else $error("start bit not low");
  a_tx_stop_high: assert property (tx_state == uadp_pkg::tx_stop |-> txd) // R2
    else $error("stop bit not high");
  a_tx_finish: assert property (tx_state == uadp_pkg::tx_data |=> tx_state != uadp_pkg::tx_idle) // R19
    else $error("transmit frame cut short");
  a_ovr_status: assert property (ovr_event |=> rsr_oe && ovr_pend) // R14
    else $error("overrun not flagged at once");
  a_ovr_nowrite: assert property (rx_done && rx_full && !rx_pop |=> rx_full && $stable(rx_head)) // R16
    else $error("full fifo changed on overrun");
  a_ecr_clear: assert property (wr_ecr && !ovr_event |=> {rsr_oe, rsr_be, rsr_pe, rsr_fe} == 4'h0) // R15
    else $error("status not cleared by write");
  a_rsr_on_read: assert property (rx_pop |=> rsr_fe == $past(rd_entry[uadp_pkg::POS_FE])
                                    && rsr_be == $past(rd_entry[uadp_pkg::POS_BE])) // R13
    else $error("status not loaded from read char");
  a_rsr_hold: assert property (!rx_pop && !wr_ecr |=> $stable({rsr_be, rsr_pe, rsr_fe})) // R13
    else $error("status flags moved without read");
  a_break_zero: assert property (rx_push && rx_be |-> rx_wdata[7:0] == 8'h00
                                 && rx_wdata[uadp_pkg::POS_FE]) // R8
    else $error("break entry not a zero char");
  a_break_wait: assert property (rx_state == uadp_pkg::rx_brk && !rx_line |=> rx_state == uadp_pkg::rx_brk) // R8
    else $error("receiver left break while line low");

  c_tx_frame: cover property (tx_state == uadp_pkg::tx_stop ##1 tx_state == uadp_pkg::tx_idle);
  c_rx_store: cover property (rx_push && !rx_fe);
  c_overrun: cover property (ovr_event);
  c_break: cover property (rx_push && rx_be);
endmodule

// ### core/uadp_pkg.sv
// package: register map, fields, reset values and states for the uart data path
// How it works
// R1: data write pushes tx fifo or holding slot
// R2: written character sent with start, parity, stops
// R3: fifo mode stores 12-bit entries with status
// R4: non-fifo mode uses single receive holding slot
// R5: data read gives char and four flags
// R6: overrun set when full, cleared on next store
// R7: break when line low whole word time
// R8: break stores one zero char, waits marking
// R9: parity error against selected parity mode
// R10: framing error when stop bit is low
// R11: status bits travel with their own character
// R12: status read gives frame, parity, break, overrun
// R13: status flags refresh only on data read
// R14: status overrun set at once on overrun
// R15: any status write clears all four flags; an overrun in the same cycle keeps overrun set
// R16: full fifo never written on overrun
// R17: reset clears receive status to zero
// R18: software disables uart before reprogramming controls
// R19: disable finishes current character before stopping
// R20: software reads data before its status
// R21: fifo enable bit selects fifo or slot
// R22: data read removes returned character from fifo
package uadp_pkg;
  // widths and depths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ENTRY_W = 12;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DIV_W = 16;
  localparam logic [4:0] CNT_FULL = 5'h10;
  // register byte offsets
  localparam logic [11:0] OFF_DATA = 12'h000;
  localparam logic [11:0] OFF_RSR = 12'h004;
  localparam logic [11:0] OFF_FLAG = 12'h018;
  localparam logic [11:0] OFF_DIV = 12'h024;
  localparam logic [11:0] OFF_LCRH = 12'h02c;
  localparam logic [11:0] OFF_CTRL = 12'h030;
  // receive entry and data register status positions
  localparam int unsigned POS_FE = 8;
  localparam int unsigned POS_PE = 9;
  localparam int unsigned POS_BE = 10;
  localparam int unsigned POS_OE = 11;
  // line control high fields
  localparam int unsigned LCR_PEN = 1;
  localparam int unsigned LCR_EVEN = 2;
  localparam int unsigned LCR_TWO_STOP = 3;
  localparam int unsigned LCR_FIFO_ON = 4;
  localparam int unsigned LCR_STICK = 7;
  // control field
  localparam int unsigned CTRL_EN = 0;
  // reset values
  localparam logic [7:0] RST_LCRH = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0000;
  localparam logic [3:0] RST_RSR = 4'h0;
  // transmit engine states
  typedef enum logic [4:0] {
    tx_idle = 5'h01,
    tx_start = 5'h02,
    tx_data = 5'h04,
    tx_par = 5'h08,
    tx_stop = 5'h10
  } uadp_tx_t;
  // receive engine states
  typedef enum logic [5:0] {
    rx_idle = 6'h01,
    rx_start = 6'h02,
    rx_data = 6'h04,
    rx_par = 6'h08,
    rx_stop = 6'h10,
    rx_brk = 6'h20
  } uadp_rx_t;
endpackage

// ### core/uadp_sync.sv
// three-stage input synchroniser with agreement filter
module uadp_sync
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // async input and filtered level
  input wire logic din,
  output logic dout
);
  logic s1; // first stage, read only by s2
  logic s2;
  logic s3;

  // shift chain; output moves only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
      begin
        dout <= s3;
      end
    end
  end
endmodule

// ### core/uadp_fifo.sv
// fifo with switchable single-slot mode
module uadp_fifo
#(
  parameter int unsigned WIDTH = 8
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // mode: one slot when set
  input wire logic single_mode,
  // fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  // drain side
  input wire logic pop,
  output logic [WIDTH-1:0] rdata,
  output logic empty,
  output logic full
);
  logic [WIDTH-1:0] mem [uadp_pkg::FIFO_DEPTH]; // storage
  logic [uadp_pkg::PTR_W-1:0] wr_ptr;
  logic [uadp_pkg::PTR_W-1:0] rd_ptr;
  logic [uadp_pkg::CNT_W-1:0] count;
  logic do_push;
  logic do_pop;

  // single mode fills at one entry, in whichever slot wr_ptr points to
  assign empty = (count == '0);
  assign full = single_mode ? !empty : (count == uadp_pkg::CNT_FULL);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign rdata = mem[rd_ptr];

  // storage write, never on a full fifo
  always_ff @(posedge pclk)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= wdata;
    end
  end

  // pointers and fill count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count <= count + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ### bench/uadp_line_model.sv
// far-side serial model: drives frames onto rxd and collects frames seen on txd
module uadp_line_model
(
  // clock
  input wire logic pclk,
  // serial line
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_len = 4; // pclk cycles per bit, equal to the programmed divisor
  logic [8:0] cap; // frame being collected: {parity or stop, data}
  logic [8:0] got_q[$]; // collected frames in arrival order
  initial rxd = 1'b1; // marking while idle
  // one bit cell, launched just after a rising edge
  task automatic put_bit(input logic b);
    @(posedge pclk);
    rxd <= b;
    repeat (bit_len - 1) @(posedge pclk);
  endtask
  // start, data lsb first, parity when par is 0 or 1, stop, then idle marking
  task automatic send(input logic [7:0] d, input int par, input logic stp);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++)
      put_bit(d[i]);
    if (par >= 0)
      put_bit(par[0]);
    put_bit(stp);
    put_bit(1'b1);
    put_bit(1'b1);
  endtask
  // line held low beyond a whole word, then released to marking
  task automatic send_break();
    repeat (12) put_bit(1'b0);
    repeat (3) put_bit(1'b1);
  endtask
  // sample txd mid-bit: data 0..7 then the next cell (parity when enabled, else stop)
  always
  begin
    @(negedge txd);
    repeat (bit_len / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (bit_len) @(posedge pclk);
      cap[i] = txd;
    end
    got_q.push_back(cap);
  end
endmodule

// ### bench/uadp_uart_data_tb_top.sv
// testbench: apb register tasks and serial scenarios for the uart data path
module uadp_uart_data_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_DR = uadp_pkg::OFF_DATA; // data register
  localparam logic [11:0] A_RS = uadp_pkg::OFF_RSR; // status / error clear
  localparam logic [11:0] A_LC = uadp_pkg::OFF_LCRH; // line control high
  localparam logic [11:0] A_CT = uadp_pkg::OFF_CTRL; // control
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [uadp_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd;
  logic txd;
  logic [31:0] rd; // last read data
  logic err; // last error response
  int n_mismatch = 0;
  int compares = 0;
  // clock: 25 ns period
  always #12.5 pclk = ~pclk;
  uadp_uart_data dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));
  uadp_line_model line (.pclk(pclk), .txd(txd), .rxd(rxd));
  // counted comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50)
      chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read and compare
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // compare next frame collected from txd
  task automatic tx_chk(input logic [8:0] e);
    logic [8:0] g;
    g = (line.got_q.size() > 0) ? line.got_q.pop_front() : 9'h000;
    chk({23'h0, g}, {23'h0, e});
  endtask
  // verdict and end of run
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(A_RS, 32'h0);
    rchk(A_LC, 32'h0);
    rchk(A_CT, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, err}, 32'h1);
    // transmit in fifo mode, back to back writes
    apb(1'b1, uadp_pkg::OFF_DIV, 32'h4);
    apb(1'b1, A_LC, 32'h10);
    apb(1'b1, A_CT, 32'h1);
    apb(1'b1, A_DR, 32'ha5);
    apb(1'b1, A_DR, 32'h3c);
    repeat (130) @(posedge pclk);
    tx_chk(9'h1a5);
    tx_chk(9'h13c);
    // disable in mid-frame, character still completes
    apb(1'b1, A_DR, 32'h5a);
    repeat (12) @(posedge pclk);
    apb(1'b1, A_CT, 32'h0);
    repeat (60) @(posedge pclk);
    tx_chk(9'h15a);
    // receive in fifo mode with even parity
    apb(1'b1, A_LC, 32'h16);
    apb(1'b1, A_CT, 32'h1);
    line.send(8'h3c, 0, 1'b1);
    line.send(8'h81, 1, 1'b1);
    line.send(8'h7e, 0, 1'b0);
    rchk(A_RS, 32'h0);
    rchk(A_DR, 32'h03c);
    rchk(A_RS, 32'h0);
    rchk(A_DR, 32'h281);
    rchk(A_RS, 32'h2);
    rchk(A_DR, 32'h17e);
    rchk(A_RS, 32'h1);
    // break: one zero character only
    line.send_break();
    rchk(A_DR, 32'h500);
    rchk(A_RS, 32'h5);
    apb(1'b0, uadp_pkg::OFF_FLAG, 32'h0);
    chk(rd & 32'h10, 32'h10);
    // stick parity, two stops: tx parity cell is one, rx parity zero is an error
    apb(1'b1, A_CT, 32'h0);
    apb(1'b1, A_LC, 32'h9a);
    apb(1'b1, A_CT, 32'h1);
    apb(1'b1, A_DR, 32'h5a);
    line.send(8'h01, 0, 1'b1);
    tx_chk(9'h15a);
    rchk(A_DR, 32'h201);
    rchk(A_RS, 32'h2);
    apb(1'b1, A_RS, 32'h0);
    rchk(A_RS, 32'h0);
    // overrun in single holding slot mode
    apb(1'b1, A_CT, 32'h0);
    apb(1'b1, A_LC, 32'h00);
    apb(1'b1, A_CT, 32'h1);
    line.send(8'h11, -1, 1'b1);
    line.send(8'h22, -1, 1'b1);
    rchk(A_RS, 32'h8);
    rchk(A_DR, 32'h811);
    line.send(8'h33, -1, 1'b1);
    rchk(A_DR, 32'h833);
    line.send(8'h44, -1, 1'b1);
    rchk(A_DR, 32'h044);
    apb(1'b1, A_RS, 32'hff);
    rchk(A_RS, 32'h0);
    print_verdict();
  end
endmodule
